// File: design/cwm_top.sv
// Selective wake frame configuration registers and frame matcher.
// ==========================================================
`timescale 1ns/1ns
module cwm_top
   import cwm_pkg::*;
(
   input  wire logic       CLK,          // 20 MHz clock
   input  wire logic       RSTN,         // Power-on reset, sync, active low
   input  wire logic       SOFT_RST,     // Soft reset pulse, clears registers
   input  wire logic       WR_EN,        // Register write strobe
   input  wire logic [6:0] ADDR,         // Register address
   input  wire logic [7:0] WDATA,        // Write data
   output      logic [7:0] RDATA,        // Read data of ADDR, registered
   input  wire logic       CFG_SET,      // Host sets config valid flag
   input  wire logic       RX_VALID,     // Received header pulse
   input  wire logic [28:0] RX_ID,       // Received identifier
   input  wire logic       RX_EXT,       // Received format bit
   input  wire logic       RX_RTR,       // Received remote bit
   input  wire logic [3:0] RX_LEN,       // Received length code
   output      logic       CONFIG_VALID, // Config valid flag
   output      logic       WAKE_UP_FRAME // One-cycle wake detection
);
   import cwm_pkg::*;

   logic [7:0] id_hi_ff, id_mid_ff, id_lo_ff, id_flg_ff;
   logic [7:0] mk_hi_ff, mk_mid_ff, mk_lo_ff, mk_bit_ff, len_ff;
   logic [7:0] rdata_ff;
   logic       cfg_valid_ff, wake_ff;

   // ==========================================================
   // Address decode
   // ==========================================================
   // Soft reset clears only the configuration bytes; the valid flag and the read
   // register follow the power-on reset alone.
   wire logic clr       = ~RSTN | SOFT_RST;
   wire logic we_id_hi  = WR_EN & (ADDR == OFS_ID_HIGH);
   wire logic we_id_mid = WR_EN & (ADDR == OFS_ID_MID);
   wire logic we_id_lo  = WR_EN & (ADDR == OFS_ID_LOW);
   wire logic we_id_flg = WR_EN & (ADDR == OFS_ID_FLAGS);
   wire logic we_mk_hi  = WR_EN & (ADDR == OFS_MSK_HIGH);
   wire logic we_mk_mid = WR_EN & (ADDR == OFS_MSK_MID);
   wire logic we_mk_lo  = WR_EN & (ADDR == OFS_MSK_LOW);
   wire logic we_mk_bit = WR_EN & (ADDR == OFS_MSK_BITS);
   wire logic we_len    = WR_EN & (ADDR == OFS_LEN_CODE);
   wire logic cfg_write = we_id_hi | we_id_mid | we_id_lo | we_id_flg | we_mk_hi
                        | we_mk_mid | we_mk_lo | we_mk_bit | we_len;

   // ==========================================================
   // Configuration registers
   // ==========================================================
   // Reserved bits are masked at write time, so they can never become one.
   always_ff @(posedge CLK)
   begin
      if (clr)
      begin
         id_hi_ff  <= RST_BYTE;
         id_mid_ff <= RST_BYTE;
         id_lo_ff  <= RST_BYTE;
         id_flg_ff <= RST_BYTE;
         mk_hi_ff  <= RST_BYTE;
         mk_mid_ff <= RST_BYTE;
         mk_lo_ff  <= RST_BYTE;
         mk_bit_ff <= RST_BYTE;
         len_ff    <= RST_BYTE;
      end
      else
      begin
         if (we_id_hi)  id_hi_ff  <= WDATA;
         if (we_id_mid) id_mid_ff <= WDATA;
         if (we_id_lo)  id_lo_ff  <= WDATA;
         if (we_id_flg) id_flg_ff <= WDATA & MASK_FLAGS_RD;
         if (we_mk_hi)  mk_hi_ff  <= WDATA;
         if (we_mk_mid) mk_mid_ff <= WDATA;
         if (we_mk_lo)  mk_lo_ff  <= WDATA;
         if (we_mk_bit) mk_bit_ff <= WDATA & MASK_MBITS_RD;
         if (we_len)    len_ff    <= WDATA & MASK_LEN_RD;
      end
   end

   // ==========================================================
   // Read back
   // ==========================================================
   // Unmapped addresses read zero, so a host probing the map never sees stale data.
   logic [7:0] rd_mux;
   always_comb
   begin
      unique case (ADDR)
         OFS_ID_HIGH:  rd_mux = id_hi_ff;
         OFS_ID_MID:   rd_mux = id_mid_ff;
         OFS_ID_LOW:   rd_mux = id_lo_ff;
         OFS_ID_FLAGS: rd_mux = id_flg_ff;
         OFS_MSK_HIGH: rd_mux = mk_hi_ff;
         OFS_MSK_MID:  rd_mux = mk_mid_ff;
         OFS_MSK_LOW:  rd_mux = mk_lo_ff;
         OFS_MSK_BITS: rd_mux = mk_bit_ff;
         OFS_LEN_CODE: rd_mux = len_ff;
         default:      rd_mux = RST_BYTE;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         rdata_ff <= RST_BYTE;
      else
         rdata_ff <= rd_mux;
   end

   // ==========================================================
   // Matching
   // ==========================================================
   wire logic [28:0] cfg_id   = {id_hi_ff, id_mid_ff, id_lo_ff,
                                 id_flg_ff[POS_LOW_MSB:POS_LOW_LSB]};
   wire logic [28:0] cfg_mask = {mk_hi_ff, mk_mid_ff, mk_lo_ff,
                                 mk_bit_ff[POS_LOW_MSB:POS_LOW_LSB]};
   wire logic        hit;

   cwm_compare #(.ID_BITS(ID_W)) u_cmp (
      .cfg_id   (cfg_id),
      .cfg_mask (cfg_mask),
      .cfg_ext  (id_flg_ff[POS_FORMAT]),
      .cfg_rtr  (id_flg_ff[POS_REMOTE]),
      .cfg_len  (len_ff[LEN_W-1:0]),
      .rx_id    (RX_ID),
      .rx_ext   (RX_EXT),
      .rx_rtr   (RX_RTR),
      .rx_len   (RX_LEN),
      .hit      (hit)
   );

   // A standard identifier sits in bits 28 down to 18, so the host leaves the low
   // bits zero or masked off; the comparator itself treats both formats alike.
   // Matching is armed only while the configuration is declared valid.
   wire logic wake_evt = RX_VALID & cfg_valid_ff & hit;

   // A config write in the same cycle as a set leaves the flag clear: the host
   // must revalidate after the last change, so the clear wins deliberately.
   wire logic nxt_cfg_valid = (cfg_write | wake_evt) ? 1'b0 :
                              (CFG_SET ? 1'b1 : cfg_valid_ff);

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         cfg_valid_ff <= 1'b0;
         wake_ff      <= 1'b0;
      end
      else
      begin
         cfg_valid_ff <= nxt_cfg_valid;
         wake_ff      <= wake_evt;
      end
   end

   assign RDATA         = rdata_ff;
   assign CONFIG_VALID  = cfg_valid_ff;
   assign WAKE_UP_FRAME = wake_ff;

   // ==========================================================
   // Checks
   // ==========================================================
   a_wake_needs_valid: assert property (@(posedge CLK) disable iff (!RSTN)
      WAKE_UP_FRAME |-> $past(cfg_valid_ff) && !cfg_valid_ff)
      else $error("wake without valid config or flag not cleared");
   a_write_clears_valid: assert property (@(posedge CLK) disable iff (!RSTN)
      cfg_write |=> !CONFIG_VALID)
      else $error("config write did not clear valid flag");
   a_len_reserved_zero: assert property (@(posedge CLK) disable iff (!RSTN)
      len_ff[7:4] == 4'h0)
      else $error("length code reserved bits set");
   a_mask_reserved_zero: assert property (@(posedge CLK) disable iff (!RSTN)
      (mk_bit_ff & ~MASK_MBITS_RD) == 8'h00)
      else $error("mask reserved bits set");
   a_flag_reserved_zero: assert property (@(posedge CLK) disable iff (!RSTN)
      id_flg_ff[7] == 1'b0)
      else $error("identifier reserved bit set");
   a_len_exact_match: assert property (@(posedge CLK) disable iff (!RSTN)
      (RX_VALID && cfg_valid_ff && RX_LEN != len_ff[3:0]) |=> !WAKE_UP_FRAME)
      else $error("wake with different length code");
   a_masked_id_match: assert property (@(posedge CLK) disable iff (!RSTN)
      (RX_VALID && cfg_valid_ff && (((RX_ID ^ cfg_id) & cfg_mask) != 29'h0))
      |=> !WAKE_UP_FRAME)
      else $error("wake with masked identifier mismatch");
   a_full_match_wakes: assert property (@(posedge CLK) disable iff (!RSTN)
      (RX_VALID && cfg_valid_ff && (((RX_ID ^ cfg_id) & cfg_mask) == 29'h0)
       && RX_EXT == id_flg_ff[0] && RX_RTR == id_flg_ff[1] && RX_LEN == len_ff[3:0])
      |=> WAKE_UP_FRAME)
      else $error("matching frame did not wake");
   a_soft_reset_clear: assert property (@(posedge CLK) disable iff (!RSTN)
      SOFT_RST |=> (id_hi_ff == 8'h00 && mk_hi_ff == 8'h00 && len_ff == 8'h00))
      else $error("soft reset did not clear registers");
   // Stored fields must equal the write that made them, minus the reserved bits.
   a_id_byte_store: assert property (@(posedge CLK) disable iff (!RSTN)
      (we_id_hi && !SOFT_RST) |=> id_hi_ff == $past(WDATA))
      else $error("identifier byte not stored");
   a_flag_store: assert property (@(posedge CLK) disable iff (!RSTN)
      (we_id_flg && !SOFT_RST) |=> id_flg_ff == ($past(WDATA) & MASK_FLAGS_RD))
      else $error("format or remote flag not stored");
   a_len_store: assert property (@(posedge CLK) disable iff (!RSTN)
      (we_len && !SOFT_RST) |=> len_ff == ($past(WDATA) & MASK_LEN_RD))
      else $error("length code not stored");
   // Frames that arrive while the configuration is not valid must stay silent.
   a_idle_no_wake: assert property (@(posedge CLK) disable iff (!RSTN)
      (RX_VALID && !cfg_valid_ff) |=> !WAKE_UP_FRAME)
      else $error("wake while configuration not valid");
   a_set_takes_flag: assert property (@(posedge CLK) disable iff (!RSTN)
      (CFG_SET && !cfg_write && !wake_evt) |=> CONFIG_VALID)
      else $error("config valid flag not set");
   a_format_match: assert property (@(posedge CLK) disable iff (!RSTN)
      (RX_VALID && cfg_valid_ff && RX_EXT != id_flg_ff[POS_FORMAT]) |=> !WAKE_UP_FRAME)
      else $error("wake with different identifier format");
endmodule : cwm_top

// File: design/cwm_pkg.sv
// Package: register map, field layout and reset values of the wake frame matcher.
package cwm_pkg;
   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [6:0] OFS_ID_HIGH   = 7'h23;
   localparam logic [6:0] OFS_ID_MID    = 7'h24;
   localparam logic [6:0] OFS_ID_LOW    = 7'h25;
   localparam logic [6:0] OFS_ID_FLAGS  = 7'h26;
   localparam logic [6:0] OFS_MSK_HIGH  = 7'h27;
   localparam logic [6:0] OFS_MSK_MID   = 7'h28;
   localparam logic [6:0] OFS_MSK_LOW   = 7'h29;
   localparam logic [6:0] OFS_MSK_BITS  = 7'h2a;
   localparam logic [6:0] OFS_LEN_CODE  = 7'h2b;
   // ==========================================================
   // Field layout and reset values
   // ==========================================================
   localparam int         POS_FORMAT    = 0;
   localparam int         POS_REMOTE    = 1;
   localparam int         POS_LOW_LSB   = 2;
   localparam int         POS_LOW_MSB   = 6;
   localparam logic [7:0] MASK_FLAGS_RD = 8'h7f;
   localparam logic [7:0] MASK_MBITS_RD = 8'h7c;
   localparam logic [7:0] MASK_LEN_RD   = 8'h0f;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam int         ID_W          = 29;
   localparam int         LEN_W         = 4;
endpackage : cwm_pkg

// File: design/cwm_compare.sv
// Combinational compare of a received frame header against the configured wake frame.
`timescale 1ns/1ns
module cwm_compare
   import cwm_pkg::*;
#(
   parameter int ID_BITS = 29
)
(
   input  wire logic [ID_BITS-1:0] cfg_id,      // Expected identifier
   input  wire logic [ID_BITS-1:0] cfg_mask,    // One marks a compared bit
   input  wire logic               cfg_ext,     // Expected format
   input  wire logic               cfg_rtr,     // Expected remote flag
   input  wire logic [3:0]         cfg_len,     // Expected length code
   input  wire logic [ID_BITS-1:0] rx_id,       // Received identifier
   input  wire logic               rx_ext,      // Received format
   input  wire logic               rx_rtr,      // Received remote flag
   input  wire logic [3:0]         rx_len,      // Received length code
   output      logic               hit          // Frame matches
);
   // The top packs exactly ID_W identifier bits, so no other width can be served.
   if (ID_BITS != ID_W)
   begin : g_bad_width
      $error("identifier width must equal the packed register width");
   end

   wire logic [ID_BITS-1:0] bit_ok;
   genvar g;
   generate
      for (g = 0; g < ID_BITS; g++)
      begin : g_bit
         assign bit_ok[g] = ~cfg_mask[g] | (cfg_id[g] == rx_id[g]);
      end
   endgenerate
   // Length code compared raw, so 8 and 15 do not match each other.
   wire logic len_ok = (cfg_len == rx_len);
   assign hit = (&bit_ok) & (cfg_ext == rx_ext) & (cfg_rtr == rx_rtr) & len_ok;
endmodule : cwm_compare

// File: tb/cwm_node.sv
// Bus node model that hands received frame headers to the matcher.
`timescale 1ns/1ns
module cwm_node
(
   input  wire logic        clk,    // Bench clock
   output      logic        rx_v,   // Header strobe
   output      logic [28:0] rx_id,  // Received identifier
   output      logic        rx_ext, // Received format
   output      logic        rx_rtr, // Received remote flag
   output      logic [3:0]  rx_len  // Received length code
);
   // ==========================================================
   // Header delivery
   // ==========================================================
   initial {rx_v, rx_id, rx_ext, rx_rtr, rx_len} = '0;
   // Outside the strobe the fields show inverted values, so a stale header cannot match.
   task send(input logic [28:0] i, input logic e, r, input logic [3:0] l);
      @(negedge clk);
      {rx_v, rx_id, rx_ext, rx_rtr, rx_len} = {1'b1, i, e, r, l};
      @(negedge clk);
      {rx_v, rx_id, rx_ext, rx_rtr, rx_len} = {1'b0, ~i, ~e, ~r, ~l};
   endtask : send
endmodule : cwm_node

// File: tb/tb_top.sv
// Self-checking bench for the wake frame matcher with a register and match model.
`timescale 1ns/1ns
module tb_top;
   import cwm_pkg::*;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
   // ==========================================================
   // Signals and model state
   // ==========================================================
   logic        clk = 0, rstn = 0, srst = 0, wr = 0, cset = 0;
   logic [6:0]  addr = '0;
   logic [7:0]  wdat = '0, rdat;
   logic        rx_v, rx_ext, rx_rtr, cv, wake, cv_m;
   logic [28:0] rx_id;
   logic [3:0]  rx_len;
   logic [7:0]  m [9];
   logic [7:0]  wm [9] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h7c, 8'h0f};
   int          n_fail = 0, comparisons = 0, seed = 79, r;
   always #25 clk = ~clk;
   cwm_top dut (.CLK(clk), .RSTN(rstn), .SOFT_RST(srst), .WR_EN(wr), .ADDR(addr),
      .WDATA(wdat), .RDATA(rdat), .CFG_SET(cset), .RX_VALID(rx_v), .RX_ID(rx_id),
      .RX_EXT(rx_ext), .RX_RTR(rx_rtr), .RX_LEN(rx_len), .CONFIG_VALID(cv),
      .WAKE_UP_FRAME(wake));
   cwm_node node (.clk(clk), .rx_v(rx_v), .rx_id(rx_id), .rx_ext(rx_ext), .rx_rtr(rx_rtr),
      .rx_len(rx_len));
   // ==========================================================
   // Host access tasks
   // ==========================================================
   task wr_reg(input int a, input logic [7:0] d);
      @(negedge clk);
      {wr, addr, wdat} = {1'b1, a[6:0], d};
      @(negedge clk);
      wr = 0;
      if (a >= 'h23 && a <= 'h2b)
      begin
         m[a-'h23] = d & wm[a-'h23];
         cv_m = 0;
      end
      `CHK(cv, cv_m)
   endtask : wr_reg
   task rd_all;
      for (int a = 'h22; a <= 'h2c; a++)
      begin
         @(negedge clk);
         addr = a[6:0];
         @(negedge clk);
         `CHK(rdat, (a >= 'h23 && a <= 'h2b) ? m[a-'h23] : 8'h00)
      end
   endtask : rd_all
   task set_cv;
      @(negedge clk);
      cset = 1;
      @(negedge clk);
      cset = 0;
      cv_m = 1;
      `CHK(cv, 1'b1)
   endtask : set_cv
   task frame(input logic [28:0] i, input logic e, rr, input logic [3:0] l);
      logic h;
      h = cv_m && ((i ^ {m[0], m[1], m[2], m[3][6:2]}) & {m[4], m[5], m[6], m[7][6:2]}) == 0
         && e == m[3][0] && rr == m[3][1] && l == m[8][3:0];
      node.send(i, e, rr, l);
      `CHK(wake, h)
      if (h) cv_m = 0;
      `CHK(cv, cv_m)
   endtask : frame
   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim
   // ==========================================================
   // Scenarios
   // ==========================================================
   initial
   begin
      #250000;
      n_fail++;
      end_sim;
   end
   initial
   begin
      cv_m = 0;
      foreach (m[i]) m[i] = 8'h00;
      repeat (4) @(negedge clk);
      rstn = 1;
      rd_all;
      for (int a = 'h22; a <= 'h2c; a++)
      begin
         r = $random(seed);
         wr_reg(a, (a == 'h26) ? (r[7:0] & 8'hfd) : r[7:0]);
      end
      foreach (wm[i]) wr_reg('h23 + i, (i == 3) ? 8'hfd : 8'hff);
      rd_all;
      // Extended identifier, all bits compared, data frame; host never asks for a remote frame.
      wr_reg('h26, 8'h55);
      wr_reg('h2b, 8'h08);
      set_cv;
      frame({m[0], m[1], m[2], m[3][6:2]}, 1'b1, 1'b0, 4'hf);
      frame({m[0], m[1], m[2], m[3][6:2]}, 1'b1, 1'b0, 4'h8);
      frame({m[0], m[1], m[2], m[3][6:2]}, 1'b1, 1'b0, 4'h8);
      for (int k = 0; k < 48; k++)
      begin
         r = $random(seed);
         if (k == 24)
         begin
            wr_reg('h24, {r[2:0], 5'h00});
            wr_reg('h25, 8'h00);
            wr_reg('h26, 8'h00);
         end
         if (k % 6 == 0) wr_reg('h27 + r[9:8], r[7:0]);
         if (k % 5 != 4) set_cv;
         frame({m[0], m[1], m[2], m[3][6:2]} ^ ((k % 3 == 0) ? 29'(1) << (r[15:10] % 29) : '0),
            m[3][0] ^ (k % 7 == 3), k % 11 == 5, (k % 4 == 1) ? r[19:16] : m[8][3:0]);
      end
      set_cv;
      @(negedge clk);
      srst = 1;
      @(negedge clk);
      srst = 0;
      foreach (m[i]) m[i] = 8'h00;
      `CHK(cv, cv_m)
      rd_all;
      wr_reg('h23, 8'ha5);
      @(negedge clk);
      rstn = 0;
      repeat (2) @(negedge clk);
      rstn = 1;
      m[0] = 8'h00;
      `CHK(cv, 1'b0)
      rd_all;
      end_sim;
   end
endmodule : tb_top
